// ---- inc/dmsp_params.svh ----
`ifndef DMSP_PARAMS_SVH
`define DMSP_PARAMS_SVH

// Register offsets
`define DMSP_ADDR_CTRL 4'h0
`define DMSP_ADDR_DATA 4'h1
`define DMSP_ADDR_BAUD 4'h2
`define DMSP_ADDR_STAT 4'h3

// Reset values
`define DMSP_CTRL_RESET 8'h00
`define DMSP_BAUD_RESET 4'h0

// Mode encodings
`define DMSP_MODE_SYNC 2'h0
`define DMSP_MODE_ASYNC8 2'h1
`define DMSP_MODE_FIXED9 2'h2

// Timing counts in oscillator cycles
`define DMSP_M0_DIV_SLOW 4'hC
`define DMSP_M0_DIV_FAST 4'h4
`define DMSP_M0_RI_DELAY 4'hC
`define DMSP_T1_PRE_SLOW 4'hC
`define DMSP_T1_PRE_FAST 4'h4
`define DMSP_M2_OS_DIV 2'h3
`define DMSP_M2_OS_DIV_DBL 2'h1

// Receive sampling: three samples in the middle of 16
`define DMSP_SAMPLE_A 4'h7
`define DMSP_SAMPLE_B 4'h8
`define DMSP_SAMPLE_C 4'h9
`define DMSP_OS_LAST 4'hF

// Frame lengths
`define DMSP_FRAME_BITS8 4'hA
`define DMSP_FRAME_BITS9 4'hB

`endif

// ---- inc/dmsp_pkg.sv ----
package dmsp_pkg;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_or_speed_bit;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } dmsp_ctrl_s;

  typedef struct packed {
    logic timer1_fast_prescale;
    logic rx_baud_from_timer2;
    logic tx_baud_from_timer2;
    logic baud_double;
  } dmsp_baud_s;

  typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX, M0_WAIT} dmsp_m0_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_ARM, TX_SHIFT, TX_END} dmsp_tx_state_e;
  typedef enum logic {RX_IDLE, RX_BITS} dmsp_rx_state_e;

endpackage : dmsp_pkg

// ---- verilog/dmsp_serial_port.sv ----
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dmsp_params.svh"

module dmsp_serial_port #(
  parameter bit PORT_INDEX = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  output logic timer1_count_tick,
  output logic timer2_flag_suppress,
  output logic timer2_ext_reload_suppress,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out
);

  logic [1:0] rst_sync_reg;
  wire logic arst_n = rst_sync_reg[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  dmsp_pkg::dmsp_ctrl_s ctrl_reg, ctrl_next;
  dmsp_pkg::dmsp_baud_s baud_reg;
  logic [7:0] rx_buf_reg, reg_rdata_reg;
  logic rxd_meta_reg, rxd_sync_reg, rxd_prev_reg;
  logic rxd_out_reg, rxd_oe_reg, txd_out_reg;

  // Register decode
  wire logic wr_ctrl = reg_wr && (reg_addr == `DMSP_ADDR_CTRL);
  wire logic wr_data = reg_wr && (reg_addr == `DMSP_ADDR_DATA);
  wire logic wr_baud = reg_wr && (reg_addr == `DMSP_ADDR_BAUD);
  wire logic [1:0] mode = {ctrl_reg.mode_select_high, ctrl_reg.mode_select_low};
  wire logic is_m0 = (mode == `DMSP_MODE_SYNC);
  wire logic is_m1 = (mode == `DMSP_MODE_ASYNC8);
  wire logic mp = ctrl_reg.multiproc_or_speed_bit;

  // Baud sources; timer 2 only reachable on port 0
  wire logic tx_t2 = (PORT_INDEX == 1'b0) && baud_reg.tx_baud_from_timer2;
  wire logic rx_t2 = (PORT_INDEX == 1'b0) && baud_reg.rx_baud_from_timer2;
  assign timer2_flag_suppress = tx_t2 || rx_t2;
  assign timer2_ext_reload_suppress = tx_t2 || rx_t2;

  logic t1_phase_reg, t1_tick_reg;
  logic [3:0] t1_pre_reg;
  logic [1:0] m2_cnt_reg;
  wire logic [3:0] t1_pre_last = baud_reg.timer1_fast_prescale ?
    (`DMSP_T1_PRE_FAST - 4'h1) : (`DMSP_T1_PRE_SLOW - 4'h1);
  wire logic [1:0] m2_last = baud_reg.baud_double ? `DMSP_M2_OS_DIV_DBL : `DMSP_M2_OS_DIV;
  wire logic m2_tick = (m2_cnt_reg == m2_last);
  // Without doubling, two overflows make one of the 16 ticks per bit
  wire logic t1_tick = timer1_overflow && (baud_reg.baud_double || t1_phase_reg);
  wire logic tx_os = (mode == `DMSP_MODE_FIXED9) ? m2_tick : (tx_t2 ? timer2_overflow : t1_tick);
  wire logic rx_os = (mode == `DMSP_MODE_FIXED9) ? m2_tick : (rx_t2 ? timer2_overflow : t1_tick);
  assign timer1_count_tick = t1_tick_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      t1_phase_reg <= 1'b0;
      t1_pre_reg <= 4'h0;
      t1_tick_reg <= 1'b0;
      m2_cnt_reg <= 2'h0;
    end else begin
      t1_phase_reg <= t1_phase_reg ^ timer1_overflow;
      t1_pre_reg <= (t1_pre_reg >= t1_pre_last) ? 4'h0 : t1_pre_reg + 4'h1;
      t1_tick_reg <= (t1_pre_reg >= t1_pre_last);
      m2_cnt_reg <= m2_tick ? 2'h0 : m2_cnt_reg + 2'h1;
    end
  end

  // Mode 0 shift engine
  dmsp_pkg::dmsp_m0_state_e m0_state_reg, m0_state_next;
  logic [3:0] m0_cnt_reg, m0_cnt_next;
  logic [2:0] m0_bit_reg, m0_bit_next;
  logic [7:0] m0_shift_reg, m0_shift_next;
  logic m0_tx_set, m0_rx_set;
  wire logic [3:0] m0_div = mp ? `DMSP_M0_DIV_FAST : `DMSP_M0_DIV_SLOW;
  wire logic [3:0] m0_half = {1'b0, m0_div[3:1]};
  wire logic m0_bit_end = (m0_cnt_reg == m0_div - 4'h1);
  wire logic m0_rise = (m0_cnt_reg == m0_half);
  wire logic m0_active = (m0_state_reg == dmsp_pkg::M0_TX) || (m0_state_reg == dmsp_pkg::M0_RX);
  wire logic m0_clk_lvl = !m0_active || (m0_cnt_reg >= m0_half);
  wire logic m0_rx_start = is_m0 && ctrl_reg.rx_enable && !ctrl_reg.rx_done_flag;

  always_comb begin
    m0_state_next = m0_state_reg;
    m0_cnt_next = m0_cnt_reg;
    m0_bit_next = m0_bit_reg;
    m0_shift_next = m0_shift_reg;
    m0_tx_set = 1'b0;
    m0_rx_set = 1'b0;
    unique case (m0_state_reg)
      dmsp_pkg::M0_IDLE: begin
        m0_cnt_next = 4'h0;
        m0_bit_next = 3'h0;
        if (wr_data && is_m0) begin
          m0_state_next = dmsp_pkg::M0_TX;
          m0_shift_next = reg_wdata;
        end else if (m0_rx_start) begin
          m0_state_next = dmsp_pkg::M0_RX;
        end
      end
      dmsp_pkg::M0_TX, dmsp_pkg::M0_RX: begin
        m0_cnt_next = m0_bit_end ? 4'h0 : m0_cnt_reg + 4'h1;
        if (m0_state_reg == dmsp_pkg::M0_RX && m0_rise) begin
          m0_shift_next = {rxd_sync_reg, m0_shift_reg[7:1]};
        end
        if (m0_bit_end) begin
          m0_bit_next = m0_bit_reg + 3'h1;
          if (m0_state_reg == dmsp_pkg::M0_TX) begin
            m0_shift_next = {1'b0, m0_shift_reg[7:1]};
          end
          if (m0_bit_reg == 3'h7) begin
            if (m0_state_reg == dmsp_pkg::M0_TX) begin
              m0_state_next = dmsp_pkg::M0_IDLE;
              m0_tx_set = 1'b1;
            end else begin
              m0_state_next = dmsp_pkg::M0_WAIT;
            end
          end
        end
      end
      dmsp_pkg::M0_WAIT: begin
        m0_cnt_next = m0_cnt_reg + 4'h1;
        if (m0_cnt_reg == `DMSP_M0_RI_DELAY - 4'h1) begin
          m0_state_next = dmsp_pkg::M0_IDLE;
          m0_rx_set = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      m0_state_reg <= dmsp_pkg::M0_IDLE;
      m0_cnt_reg <= 4'h0;
      m0_bit_reg <= 3'h0;
      m0_shift_reg <= 8'h00;
    end else begin
      m0_state_reg <= m0_state_next;
      m0_cnt_reg <= m0_cnt_next;
      m0_bit_reg <= m0_bit_next;
      m0_shift_reg <= m0_shift_next;
    end
  end

  // Asynchronous transmitter
  dmsp_pkg::dmsp_tx_state_e tx_state_reg, tx_state_next;
  logic [3:0] tx16_reg, tx_left_reg, tx_left_next;
  logic [10:0] tx_shift_reg, tx_shift_next;
  logic tx_async_set;
  wire logic tx_roll = tx_os && (tx16_reg == `DMSP_OS_LAST);
  wire logic tx_stop_end = (tx_state_reg == dmsp_pkg::TX_SHIFT) && tx_roll && (tx_left_reg == 4'h1);
  // Mode 1 pads the unused ninth position with a mark
  wire logic tx_bit9 = is_m1 ? 1'b1 : ctrl_reg.tx_ninth_bit;

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_left_next = tx_left_reg;
    tx_shift_next = tx_shift_reg;
    tx_async_set = 1'b0;
    if (wr_data && !is_m0) begin
      // A write mid-frame restarts it: software must wait for tx_done_flag
      tx_state_next = dmsp_pkg::TX_ARM;
      tx_shift_next = {1'b1, tx_bit9, reg_wdata, 1'b0};
      tx_left_next = is_m1 ? `DMSP_FRAME_BITS8 : `DMSP_FRAME_BITS9;
    end else begin
      unique case (tx_state_reg)
        dmsp_pkg::TX_IDLE: begin
        end
        dmsp_pkg::TX_ARM: begin
          if (tx_roll) tx_state_next = dmsp_pkg::TX_SHIFT;
        end
        dmsp_pkg::TX_SHIFT: begin
          if (tx_roll) begin
            tx_shift_next = {1'b1, tx_shift_reg[10:1]};
            tx_left_next = tx_left_reg - 4'h1;
            if (!is_m1 && tx_left_reg == 4'h2) tx_async_set = 1'b1;
            if (tx_left_reg == 4'h1) begin
              tx_state_next = is_m1 ? dmsp_pkg::TX_END : dmsp_pkg::TX_IDLE;
            end
          end
        end
        dmsp_pkg::TX_END: begin
          tx_state_next = dmsp_pkg::TX_IDLE;
          tx_async_set = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_reg <= dmsp_pkg::TX_IDLE;
      tx16_reg <= 4'h0;
      tx_left_reg <= 4'h0;
      tx_shift_reg <= 11'h7FF;
    end else begin
      tx_state_reg <= tx_state_next;
      tx16_reg <= tx_os ? tx16_reg + 4'h1 : tx16_reg;
      tx_left_reg <= tx_left_next;
      tx_shift_reg <= tx_shift_next;
    end
  end

  // Asynchronous receiver
  dmsp_pkg::dmsp_rx_state_e rx_state_reg;
  logic [3:0] rx16_reg, rx_idx_reg;
  logic rx_s0_reg, rx_s1_reg, rx_ninth_cap_reg;
  logic [7:0] rx_shift_reg;
  wire logic rx_start = (rx_state_reg == dmsp_pkg::RX_IDLE) && !is_m0 && ctrl_reg.rx_enable &&
    rxd_prev_reg && !rxd_sync_reg;
  wire logic rx_vote_bit = (rx_s0_reg && rx_s1_reg) || (rx_s0_reg && rxd_sync_reg) ||
    (rx_s1_reg && rxd_sync_reg);
  wire logic rx_vote = (rx_state_reg == dmsp_pkg::RX_BITS) && rx_os && (rx16_reg == `DMSP_SAMPLE_C);
  wire logic [3:0] rx_last_idx = is_m1 ? `DMSP_FRAME_BITS8 - 4'h1 : `DMSP_FRAME_BITS9 - 4'h1;
  wire logic rx_at_stop = rx_vote && (rx_idx_reg == rx_last_idx);
  // Mode 1 keeps the stop bit; nine-bit modes keep the ninth data bit
  wire logic rx_ninth_val = is_m1 ? rx_vote_bit : rx_ninth_cap_reg;
  wire logic rx_async_set = rx_at_stop && !ctrl_reg.rx_done_flag && (!mp || rx_ninth_val);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_reg <= dmsp_pkg::RX_IDLE;
      rx16_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_s0_reg <= 1'b1;
      rx_s1_reg <= 1'b1;
      rx_ninth_cap_reg <= 1'b0;
      rx_shift_reg <= 8'h00;
    end else begin
      if (rx_start) begin
        rx_state_reg <= dmsp_pkg::RX_BITS;
        rx16_reg <= 4'h0;
        rx_idx_reg <= 4'h0;
      end else if (rx_os) begin
        rx16_reg <= rx16_reg + 4'h1;
      end
      if (rx_os && rx16_reg == `DMSP_SAMPLE_A) rx_s0_reg <= rxd_sync_reg;
      if (rx_os && rx16_reg == `DMSP_SAMPLE_B) rx_s1_reg <= rxd_sync_reg;
      if (rx_vote) begin
        rx_idx_reg <= rx_idx_reg + 4'h1;
        if (rx_idx_reg == 4'h0 && rx_vote_bit) rx_state_reg <= dmsp_pkg::RX_IDLE;
        if (rx_idx_reg >= 4'h1 && rx_idx_reg <= 4'h8) begin
          rx_shift_reg <= {rx_vote_bit, rx_shift_reg[7:1]};
        end
        if (rx_idx_reg == 4'h9 && !is_m1) rx_ninth_cap_reg <= rx_vote_bit;
        if (rx_at_stop) rx_state_reg <= dmsp_pkg::RX_IDLE;
      end
    end
  end

  // Control and flags: a hardware set wins over a software clear
  wire logic tx_done_set = m0_tx_set || tx_async_set;
  wire logic rx_done_set = m0_rx_set || rx_async_set;

  always_comb begin
    ctrl_next = wr_ctrl ? dmsp_pkg::dmsp_ctrl_s'(reg_wdata) : ctrl_reg;
    if (rx_async_set) ctrl_next.rx_ninth_bit = rx_ninth_val;
    ctrl_next.tx_done_flag = tx_done_set || ctrl_next.tx_done_flag;
    ctrl_next.rx_done_flag = rx_done_set || ctrl_next.rx_done_flag;
  end

  wire logic [7:0] stat_word = {5'h00, rx_state_reg == dmsp_pkg::RX_BITS, m0_active,
    tx_state_reg != dmsp_pkg::TX_IDLE};
  wire logic [7:0] rd_mux = (reg_addr == `DMSP_ADDR_CTRL) ? ctrl_reg :
    (reg_addr == `DMSP_ADDR_DATA) ? rx_buf_reg :
    (reg_addr == `DMSP_ADDR_BAUD) ? {4'h0, baud_reg} :
    (reg_addr == `DMSP_ADDR_STAT) ? stat_word : 8'h00;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `DMSP_CTRL_RESET;
      baud_reg <= `DMSP_BAUD_RESET;
      rx_buf_reg <= 8'h00;
      reg_rdata_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_baud) baud_reg <= reg_wdata[3:0];
      if (m0_rx_set) rx_buf_reg <= m0_shift_reg;
      else if (rx_async_set) rx_buf_reg <= rx_shift_reg;
      reg_rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_reg;

  // Pins: RXD synchroniser and registered outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
      txd_out_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd_in;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
      rxd_out_reg <= (m0_state_reg == dmsp_pkg::M0_TX) ? m0_shift_reg[0] : 1'b1;
      rxd_oe_reg <= (m0_state_reg == dmsp_pkg::M0_TX);
      txd_out_reg <= m0_active ? m0_clk_lvl :
        ((tx_state_reg == dmsp_pkg::TX_SHIFT) ? tx_shift_reg[0] : 1'b1);
    end
  end
  assign rxd_out = rxd_out_reg;
  assign rxd_oe = rxd_oe_reg;
  assign txd_out = txd_out_reg;

  default clocking dmsp_cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  property p_tx_flag_sw_clear;
    $fell(ctrl_reg.tx_done_flag) |-> $past(wr_ctrl) && !$past(reg_wdata[1]);
  endproperty
  a_tx_flag_sw_clear: assert property (p_tx_flag_sw_clear)
    else $error("tx done flag cleared without a software write");

  property p_rx_flag_sw_clear;
    $fell(ctrl_reg.rx_done_flag) |-> $past(wr_ctrl) && !$past(reg_wdata[0]);
  endproperty
  a_rx_flag_sw_clear: assert property (p_rx_flag_sw_clear)
    else $error("rx done flag cleared without a software write");

  property p_m0_tx_start;
    wr_data && is_m0 && m0_state_reg == dmsp_pkg::M0_IDLE |=> m0_state_reg == dmsp_pkg::M0_TX;
  endproperty
  a_m0_tx_start: assert property (p_m0_tx_start)
    else $error("mode 0 write did not start a transmission");

  property p_m0_rx_gate;
    m0_state_reg == dmsp_pkg::M0_RX && $past(m0_state_reg) == dmsp_pkg::M0_IDLE |->
      $past(ctrl_reg.rx_enable) && !$past(ctrl_reg.rx_done_flag);
  endproperty
  a_m0_rx_gate: assert property (p_m0_rx_gate)
    else $error("mode 0 reception started while not allowed");

  property p_m0_slow_clock;
    m0_active && !mp && $fell(m0_clk_lvl) |-> !m0_clk_lvl [*6] ##1 m0_clk_lvl;
  endproperty
  a_m0_slow_clock: assert property (p_m0_slow_clock)
    else $error("mode 0 shift clock low phase not six cycles");

  property p_m0_ri_delay;
    m0_state_reg == dmsp_pkg::M0_RX && m0_bit_end && m0_bit_reg == 3'h7 |->
      ##12 m0_rx_set ##1 ctrl_reg.rx_done_flag;
  endproperty
  a_m0_ri_delay: assert property (p_m0_ri_delay)
    else $error("mode 0 receive flag not set twelve cycles after bit eight");

  property p_mp_filter;
    $rose(ctrl_reg.rx_done_flag) && !$past(wr_ctrl) && mode[1] && mp |-> ctrl_reg.rx_ninth_bit;
  endproperty
  a_mp_filter: assert property (p_mp_filter)
    else $error("multiprocessor filter flagged a character with ninth bit 0");

  property p_start_align;
    rx_start |=> rx16_reg == 4'h0 && rx_state_reg == dmsp_pkg::RX_BITS;
  endproperty
  a_start_align: assert property (p_start_align)
    else $error("start edge did not reset the receive divider");

  property p_m1_tx_done;
    tx_stop_end && is_m1 && !wr_data |-> ##2 ctrl_reg.tx_done_flag;
  endproperty
  a_m1_tx_done: assert property (p_m1_tx_done)
    else $error("mode 1 tx flag not set two cycles after stop bit");

endmodule : dmsp_serial_port

// ---- sim/dmsp_far_end.sv ----
`timescale 1ns/1ps
// Remote serial device: mode 0 shift register and plain async line
module dmsp_far_end (
  input wire logic ref_clk,
  input wire logic txd,
  input wire logic rxd_oe,
  input wire logic rxd_out,
  output logic rxd_drv
);
  logic [7:0] m0_cap = 8'h00;
  logic [7:0] m0_src = 8'h00;
  logic m0_arm = 1'b0;
  int m0_per = 0;
  int m0_falls = 0;
  int idx = 0;
  longint last = 0;
  initial rxd_drv = 1'b1;
  // Shift register takes the data line on each shift clock rise
  always @(posedge txd) if (rxd_oe) begin
    m0_cap <= {rxd_out, m0_cap[7:1]};
    m0_per <= int'(($time - last) / 10);
    last <= $time;
  end
  // Next source bit is presented on each shift clock fall
  always @(negedge txd) if (!rxd_oe && m0_arm) begin
    rxd_drv <= m0_src[idx];
    idx <= (idx + 1) % 8;
    m0_falls <= m0_falls + 1;
  end
  // Once the eighth bit has been taken the released line returns to the idle mark
  always @(posedge txd) if (!rxd_oe && m0_arm && idx == 0) rxd_drv <= 1'b1;
  // Start, data, ninth, stop; an optional short inversion mid-bit
  task automatic send_async(input int n, input logic [10:0] b, input int per, input int gl);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < per; c++) begin
        @(posedge ref_clk);
        rxd_drv <= (i == gl && c >= per / 2 - 1 && c <= per / 2 + 1) ? ~b[i] : b[i];
      end
    end
    @(posedge ref_clk);
    rxd_drv <= 1'b1;
  endtask : send_async
  task automatic get_async(input int n, input int per, output logic [10:0] b);
    b = 11'h000;
    @(negedge txd);
    repeat (per / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      repeat (per) @(posedge ref_clk);
    end
  endtask : get_async
endmodule : dmsp_far_end

// ---- sim/dual_mode_serial_port_tb.sv ----
`timescale 1ns/1ps
`include "dmsp_params.svh"
module dual_mode_serial_port_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic timer1_overflow = 1'b0;
  logic timer2_overflow = 1'b0;
  logic [7:0] reg_rdata;
  logic timer1_count_tick;
  logic timer2_flag_suppress;
  logic timer2_ext_reload_suppress;
  logic rxd_in;
  logic rxd_out;
  logic rxd_oe;
  logic txd_out;
  logic rxd_drv;
  logic p1_t2_flag;
  logic p1_t2_reload;
  logic [7:0] rd_val;
  logic [10:0] frame;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  always #5 ref_clk = ~ref_clk;
  assign rxd_in = rxd_oe ? rxd_out : rxd_drv;
  dmsp_serial_port #(.PORT_INDEX(1'b0)) i_dmsp_serial_port (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
    .timer1_count_tick(timer1_count_tick), .timer2_flag_suppress(timer2_flag_suppress),
    .timer2_ext_reload_suppress(timer2_ext_reload_suppress), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
  dmsp_far_end i_dmsp_far_end (.ref_clk(ref_clk), .txd(txd_out), .rxd_oe(rxd_oe),
    .rxd_out(rxd_out), .rxd_drv(rxd_drv));
  // Second port shares the bus; it must never claim timer 2
  dmsp_serial_port #(.PORT_INDEX(1'b1)) i_dmsp_serial_port_p1 (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .timer1_overflow(timer1_overflow),
    .timer2_overflow(timer2_overflow), .timer1_count_tick(), .timer2_flag_suppress(p1_t2_flag),
    .timer2_ext_reload_suppress(p1_t2_reload), .rxd_in(rxd_in), .rxd_out(), .rxd_oe(),
    .txd_out());
  // Timer 1 overflows every 4 clocks, timer 2 every 3
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    timer1_overflow <= (cyc % 4 == 3);
    timer2_overflow <= (cyc % 3 == 2);
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_flag(input logic [7:0] m);
    for (int i = 0; i < 4000; i++) begin
      rd(`DMSP_ADDR_CTRL, rd_val);
      if ((rd_val & m) !== 8'h00) break;
    end
    chk(rd_val & m, m);
  endtask : wait_flag
  task automatic tx_async(input logic [7:0] c, input logic [7:0] b, input logic [7:0] d,
                          input int n, input int per, input logic [10:0] e);
    wr(`DMSP_ADDR_BAUD, b);
    wr(`DMSP_ADDR_CTRL, c);
    wr(`DMSP_ADDR_DATA, d);
    i_dmsp_far_end.get_async(n, per, frame);
    chk(frame, e);
    wait_flag(8'h02);
  endtask : tx_async
  task automatic rx_async(input int n, input logic [10:0] f, input int per, input int gl,
                          input logic [7:0] ec, input logic [7:0] ed);
    i_dmsp_far_end.send_async(n, f, per, gl);
    repeat (20) @(posedge ref_clk);
    rd(`DMSP_ADDR_CTRL, rd_val);
    chk(rd_val, ec);
    rd(`DMSP_ADDR_DATA, rd_val);
    chk(rd_val, ed);
  endtask : rx_async
  task automatic tick_per(input int e);
    longint t;
    @(posedge timer1_count_tick);
    @(posedge timer1_count_tick);
    t = $time;
    @(posedge timer1_count_tick);
    chk(16'(($time - t) / 10), 16'(e));
  endtask : tick_per
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`DMSP_ADDR_CTRL, rd_val);
    chk(rd_val, `DMSP_CTRL_RESET);
    rd(`DMSP_ADDR_BAUD, rd_val);
    chk(rd_val, 8'h00);
    rd(`DMSP_ADDR_STAT, rd_val);
    chk(rd_val, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h5, rd_val);
    chk(rd_val, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(`DMSP_ADDR_CTRL, s ? 8'h20 : 8'h00);
      wr(`DMSP_ADDR_DATA, s ? 8'h3C : 8'hA5);
      rd(`DMSP_ADDR_STAT, rd_val);
      chk(rd_val, 8'h02);
      wait_flag(8'h02);
      chk(i_dmsp_far_end.m0_cap, s ? 8'h3C : 8'hA5);
      chk(16'(i_dmsp_far_end.m0_per), s ? 16'h0004 : 16'h000C);
    end
    i_dmsp_far_end.m0_src = 8'h96;
    i_dmsp_far_end.m0_arm = 1'b1;
    wr(`DMSP_ADDR_CTRL, 8'h10);
    wait_flag(8'h01);
    rd(`DMSP_ADDR_DATA, rd_val);
    chk(rd_val, 8'h96);
    t0 = i_dmsp_far_end.m0_falls;
    repeat (300) @(posedge ref_clk);
    chk(16'(i_dmsp_far_end.m0_falls - t0), 16'h0000);
    rd(`DMSP_ADDR_CTRL, rd_val);
    chk(rd_val, 8'h11);
    wr(`DMSP_ADDR_CTRL, 8'h00);
    i_dmsp_far_end.m0_arm = 1'b0;
    tx_async(8'h88, 8'h00, 8'h5A, 11, 64, {2'b11, 8'h5A, 1'b0});
    tx_async(8'h80, 8'h01, 8'hC3, 11, 32, {2'b10, 8'hC3, 1'b0});
    tx_async(8'h40, 8'h00, 8'h81, 10, 128, {2'b01, 8'h81, 1'b0});
    tx_async(8'h40, 8'h01, 8'h7E, 10, 64, {2'b01, 8'h7E, 1'b0});
    tx_async(8'h40, 8'h02, 8'h42, 10, 48, {2'b01, 8'h42, 1'b0});
    tx_async(8'hC0, 8'h01, 8'h96, 11, 64, {2'b10, 8'h96, 1'b0});
    wr(`DMSP_ADDR_BAUD, 8'h00);
    wr(`DMSP_ADDR_CTRL, 8'h90);
    rx_async(11, {2'b11, 8'h69, 1'b0}, 64, 4, 8'h95, 8'h69);
    wr(`DMSP_ADDR_CTRL, 8'hB0);
    rx_async(11, {2'b10, 8'h33, 1'b0}, 64, 99, 8'hB0, 8'h69);
    rx_async(11, {2'b11, 8'h11, 1'b0}, 64, 99, 8'hB5, 8'h11);
    rx_async(11, {2'b11, 8'h22, 1'b0}, 64, 99, 8'hB5, 8'h11);
    wr(`DMSP_ADDR_BAUD, 8'h04);
    wr(`DMSP_ADDR_CTRL, 8'h50);
    rx_async(10, {2'b01, 8'hE7, 1'b0}, 48, 99, 8'h55, 8'hE7);
    wr(`DMSP_ADDR_BAUD, 8'h00);
    tick_per(12);
    @(posedge ref_clk);
    #1 chk({timer2_flag_suppress, timer2_ext_reload_suppress}, 16'h0000);
    wr(`DMSP_ADDR_BAUD, 8'h08);
    tick_per(4);
    wr(`DMSP_ADDR_BAUD, 8'h02);
    @(posedge ref_clk);
    #1 chk({timer2_flag_suppress, timer2_ext_reload_suppress}, 16'h0003);
    chk({p1_t2_flag, p1_t2_reload}, 16'h0000);
    end_of_test();
  end
endmodule : dual_mode_serial_port_tb
